/* design/sar_adc_control_defines.svh */
// Constants for the SAR converter control block
// Functional notes
// RULE_01 - Input above high reference gives full scale
// RULE_02 - Input below low reference gives zero
// RULE_03 - Enable bit starts continuous conversions
// RULE_04 - Completion stores result, sets flag
// RULE_05 - High read or status write clears flag
// RULE_06 - Software reads low then high byte
// RULE_07 - Each conversion overwrites both result bytes
// RULE_08 - Software masks interrupts during result read
// RULE_09 - Eight-bit read uses high byte only
// RULE_10 - Channel change aborts, clears flag, restarts
// RULE_11 - Speed bit picks quarter or half clock
// RULE_12 - Clearing enable stops conversion
// RULE_13 - Software writes zero to bit four
// RULE_14 - Channel code selects input directly
// RULE_15 - High byte holds result bits nine to two
// RULE_16 - Low byte holds bits one to zero
// RULE_17 - Wait mode no effect, halt disables
// RULE_18 - All registers reset to zero
// RULE_19 - One approximation step per bit, MSB first
// RULE_20 - No interrupt; flag is polled only
`ifndef SAR_ADC_CONTROL_DEFINES_SVH
`define SAR_ADC_CONTROL_DEFINES_SVH
`define ADC_CSR_OFFSET 8'h70
`define ADC_RES_HIGH_OFFSET 8'h71
`define ADC_RES_LOW_OFFSET 8'h72
`define ADC_CSR_EOC_BIT 7
`define ADC_CSR_SPEED_BIT 6
`define ADC_CSR_ENABLE_BIT 5
`define ADC_CSR_RSVD_BIT 4
`define ADC_CSR_CHAN_MSB 3
`define ADC_CSR_RESET 8'h00
`define ADC_RES_RESET 10'h000
`define ADC_RES_FULL 10'h3FF
`define ADC_RES_BITS 10
`define ADC_DIV_SLOW 2'h3
`define ADC_DIV_FAST 2'h1
`define ADC_SAMPLE_TICKS 4'h3
`endif

/* design/sar_adc_control_pkg.sv */
// Types for the SAR converter control block
package sar_adc_control_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_STEP
  } conv_state_e;
  typedef logic [9:0] result_t;
endpackage : sar_adc_control_pkg

/* design/sar_clock_divider.sv */
// Converter clock tick generator, CPU clock divided by 2 or 4
`timescale 1ns/1ps
`include "sar_adc_control_defines.svh"
module sar_clock_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic half_rate,
  output logic tick
);
  logic [1:0] count_r;
  logic [1:0] limit;
  assign limit = half_rate ? `ADC_DIV_FAST : `ADC_DIV_SLOW; // RULE_11
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 2'h0;
    end else if (!run || count_r >= limit) begin
      count_r <= 2'h0;
    end else begin
      count_r <= count_r + 2'h1;
    end
  end
  // Restarting from zero keeps every conversion at the same length
  assign tick = run && (count_r >= limit);
endmodule : sar_clock_divider

/* design/sar_adc_control.sv */
// SAR converter control, result registers and Wishbone slave
`timescale 1ns/1ps
`include "sar_adc_control_defines.svh"
module sar_adc_control (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic HALT_MODE,
  input wire logic COMPARATOR_IN,
  input wire logic ABOVE_HIGH_REFERENCE,
  input wire logic BELOW_LOW_REFERENCE,
  output logic [3:0] CHANNEL_SELECT,
  output logic [9:0] DAC_CODE,
  output logic SAMPLE_HOLD,
  output logic CONVERTER_POWER
);
  logic rst_sync1_r;
  logic rst_n;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_n <= rst_sync1_r;
    end
  end

  // Pin inputs through two flops; only the second stage is read
  logic [3:0] pin_raw;
  wire [3:0] pin_r;
  assign pin_raw = {HALT_MODE, COMPARATOR_IN, ABOVE_HIGH_REFERENCE, BELOW_LOW_REFERENCE};
  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pin_raw[g];
          sync_r <= meta_r;
        end
      end
      assign pin_r[g] = sync_r;
    end
  endgenerate

  logic halt_s;
  logic cmp_s;
  logic above_s;
  logic below_s;
  assign halt_s = pin_r[3];
  assign cmp_s = pin_r[2];
  assign above_s = pin_r[1];
  assign below_s = pin_r[0];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  logic addr_csr;
  logic addr_high;
  logic bus_req;
  logic wr_csr;
  logic rd_high;
  assign addr_csr = hit(WB_ADR_I, `ADC_CSR_OFFSET);
  assign addr_high = hit(WB_ADR_I, `ADC_RES_HIGH_OFFSET);

  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_csr = bus_req && WB_WE_I && WB_SEL_I[0] && addr_csr;
  assign rd_high = bus_req && !WB_WE_I && addr_high;

  logic eoc_r;
  logic speed_r;
  logic enable_r;
  logic [3:0] chan_r;
  sar_adc_control_pkg::result_t result_r;
  sar_adc_control_pkg::conv_state_e state_r;
  sar_adc_control_pkg::result_t trial_r;
  logic [3:0] bit_r;
  logic [3:0] sample_r;
  logic tick;
  logic chan_change;
  logic running;
  logic done;
  logic step;

  logic settled;
  logic [1:0] settle_r;
  sar_adc_control_pkg::result_t result_nxt;

  // Only a different channel aborts; the same channel just clears the flag
  assign chan_change = wr_csr && (WB_DAT_I[`ADC_CSR_CHAN_MSB:0] != chan_r);
  assign running = enable_r && !halt_s; // RULE_17

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      speed_r <= 1'(`ADC_CSR_RESET >> `ADC_CSR_SPEED_BIT); // RULE_18
    end else if (wr_csr) begin
      speed_r <= WB_DAT_I[`ADC_CSR_SPEED_BIT]; // RULE_11
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 1'(`ADC_CSR_RESET >> `ADC_CSR_ENABLE_BIT); // RULE_18
    end else if (wr_csr) begin
      enable_r <= WB_DAT_I[`ADC_CSR_ENABLE_BIT]; // RULE_03 RULE_12
    end
  end

  // Bit 4 is not stored, so it always reads zero
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      chan_r <= 4'(`ADC_CSR_RESET); // RULE_18
    end else if (wr_csr) begin
      chan_r <= WB_DAT_I[`ADC_CSR_CHAN_MSB:0]; // RULE_14
    end
  end

  // Ticks only while converting, so every conversion starts in phase
  sar_clock_divider u_div (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .run(running && state_r != sar_adc_control_pkg::CONV_IDLE),
    .half_rate(speed_r),
    .tick(tick)
  );

  assign step = state_r == sar_adc_control_pkg::CONV_STEP && tick && settled;
  assign done = running && !chan_change && step && bit_r == 4'h0;

  // Comparator pin trails the DAC code by three clocks (register plus
  // synchroniser), so a half-rate tick waits until it has settled
  assign settled = (settle_r == 2'h3);
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= 2'h0;
    end else if (state_r != sar_adc_control_pkg::CONV_STEP || step) begin
      settle_r <= 2'h0;
    end else if (!settled) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sar_adc_control_pkg::CONV_IDLE;
      sample_r <= 4'h0;
    end else if (!running || chan_change) begin
      state_r <= sar_adc_control_pkg::CONV_IDLE; // RULE_12 RULE_10
      sample_r <= 4'h0;
    end else begin
      case (state_r)
        sar_adc_control_pkg::CONV_IDLE: begin
          state_r <= sar_adc_control_pkg::CONV_SAMPLE; // RULE_03
          sample_r <= 4'h0;
        end
        sar_adc_control_pkg::CONV_SAMPLE: begin
          if (tick && sample_r == `ADC_SAMPLE_TICKS) begin
            state_r <= sar_adc_control_pkg::CONV_STEP;
          end else if (tick) begin
            sample_r <= sample_r + 4'h1;
          end
        end
        sar_adc_control_pkg::CONV_STEP: begin
          if (step && bit_r == 4'h0) begin
            state_r <= sar_adc_control_pkg::CONV_IDLE; // RULE_03
          end
        end
        default: begin
          state_r <= sar_adc_control_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // Trial register drives the DAC; one bit decided per step, MSB first
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      trial_r <= `ADC_RES_RESET;
      bit_r <= 4'h0;
    end else if (!running || chan_change) begin
      trial_r <= `ADC_RES_RESET; // RULE_12 RULE_10
      bit_r <= 4'h0;
    end else if (state_r == sar_adc_control_pkg::CONV_SAMPLE && tick &&
                 sample_r == `ADC_SAMPLE_TICKS) begin
      bit_r <= 4'(`ADC_RES_BITS - 1);
      trial_r <= 10'h200;
    end else if (step) begin
      // Keep the trial bit if the input is above the DAC level
      trial_r[bit_r] <= cmp_s; // RULE_19
      if (bit_r != 4'h0) begin
        trial_r[bit_r - 4'h1] <= 1'b1;
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  // Not latched: a new result overwrites both bytes
  always_comb begin
    result_nxt = {trial_r[9:1], cmp_s}; // RULE_04
    if (above_s) begin
      result_nxt = `ADC_RES_FULL; // RULE_01
    end else if (below_s) begin
      result_nxt = `ADC_RES_RESET; // RULE_02
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= `ADC_RES_RESET; // RULE_18
    end else if (done) begin
      result_r <= result_nxt; // RULE_04 RULE_07
    end
  end

  logic eoc_clear;
  assign eoc_clear = rd_high || wr_csr; // RULE_05

  // Completion wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      eoc_r <= 1'b0;
    end else if (done) begin
      eoc_r <= 1'b1; // RULE_04 RULE_20
    end else if (eoc_clear) begin
      eoc_r <= 1'b0; // RULE_05 RULE_10
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (WB_ADR_I)
      `ADC_CSR_OFFSET: begin
        rd_byte = {eoc_r, speed_r, enable_r, 1'b0, chan_r};
      end
      `ADC_RES_HIGH_OFFSET: begin
        rd_byte = result_r[9:2]; // RULE_15
      end
      `ADC_RES_LOW_OFFSET: begin
        rd_byte = {6'h00, result_r[1:0]}; // RULE_16
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Unmapped addresses are acknowledged and read zero
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_DAT_O <= 32'h00000000;
    end else if (bus_req && !WB_WE_I) begin
      WB_DAT_O <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CHANNEL_SELECT <= 4'h0;
    end else begin
      CHANNEL_SELECT <= chan_r; // RULE_14
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DAC_CODE <= 10'h000;
    end else begin
      DAC_CODE <= trial_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SAMPLE_HOLD <= 1'b0;
    end else begin
      SAMPLE_HOLD <= running && state_r == sar_adc_control_pkg::CONV_SAMPLE;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CONVERTER_POWER <= 1'b0;
    end else begin
      CONVERTER_POWER <= running; // RULE_12 RULE_17
    end
  end
endmodule : sar_adc_control

/* test/analog_front.sv */
// Analog mux, comparator and reference detector model
`timescale 1ns/1ps
module analog_front (
  input wire logic [3:0] CHANNEL_SELECT,
  input wire logic [9:0] DAC_CODE,
  output logic COMPARATOR_IN,
  output logic ABOVE_HIGH_REFERENCE,
  output logic BELOW_LOW_REFERENCE
);
  // Half-code offset so the trial compare is never a tie
  logic [10:0] level;
  assign level = {CHANNEL_SELECT, 6'h2A, 1'b1};
  assign COMPARATOR_IN = level > {DAC_CODE, 1'b0};
  assign ABOVE_HIGH_REFERENCE = CHANNEL_SELECT == 4'hF;
  assign BELOW_LOW_REFERENCE = CHANNEL_SELECT == 4'h0;
endmodule : analog_front

/* test/sar_adc_control_assertions.sv */
// Port assertions for the SAR converter control block
`timescale 1ns/1ps
module sar_adc_control_assertions (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic HALT_MODE,
  input wire logic [3:0] CHANNEL_SELECT,
  input wire logic SAMPLE_HOLD,
  input wire logic CONVERTER_POWER
);
  logic req;
  logic csr_wr;
  logic [3:0] ch_r;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign csr_wr = req && WB_WE_I && WB_ADR_I == 8'h70 && WB_SEL_I[0];
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) ch_r <= 4'h0;
    else if (csr_wr) ch_r <= WB_DAT_I[3:0];
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_answers: assert property (req |=> WB_ACK_O) else $error("no ack");
  a_no_stray_ack: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("stray ack");
  a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper data set");
  a_low_pad_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h72
    |-> WB_DAT_O[7:2] == 6'h00) else $error("low pad set");
  a_halt_off: assert property (HALT_MODE [*4] |=> !CONVERTER_POWER)
    else $error("power in halt");
  a_chan_follows: assert property (csr_wr |=> ##2 CHANNEL_SELECT == ch_r)
    else $error("channel stale");
  a_off_stops: assert property (csr_wr && !WB_DAT_I[5] |=> ##[1:3] !CONVERTER_POWER)
    else $error("still powered");
  a_sample_powered: assert property ($rose(SAMPLE_HOLD) |-> CONVERTER_POWER)
    else $error("sample unpowered");
  c_csr_write: cover property (csr_wr);
  c_sample_end: cover property ($fell(SAMPLE_HOLD));
  c_halt_hit: cover property (HALT_MODE && CONVERTER_POWER);
endmodule : sar_adc_control_assertions

/* test/tb.sv */
// Bench: bus stimulus, analog model, result checks
`timescale 1ns/1ps
module tb;
  logic CORE_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic HALT_MODE = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h1;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O, COMPARATOR_IN, ABOVE_HIGH_REFERENCE, BELOW_LOW_REFERENCE;
  logic SAMPLE_HOLD, CONVERTER_POWER;
  logic [3:0] CHANNEL_SELECT;
  logic [9:0] DAC_CODE;
  logic [7:0] q;
  int miscompares = 0;
  int tests_run = 0;
  int n, m, p;
  int cyc = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) cyc <= cyc + 1;
  sar_adc_control DUT (.*);
  analog_front AF (.*);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge CORE_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_SEL_I <= 4'h1;
    WB_ADR_I <= a;
    WB_DAT_I <= {24'h0, d};
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 20);
    if (WB_ACK_O !== 1'b1) begin
      chk("ack", 10'h0, 10'h1);
      finish_test();
    end
    q = WB_DAT_O[7:0];
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {2'h0, q}, {2'h0, e});
  endtask : rd
  task automatic poll(output int c);
    c = 0;
    do begin
      wb(1'b0, 8'h70, 8'h00);
      c++;
    end while (q[7] !== 1'b1 && c < 200);
    if (q[7] !== 1'b1) begin
      chk("eoc wait", 10'h0, 10'h1);
      finish_test();
    end
  endtask : poll
  task automatic t_reset();
    rd(8'h70, 8'h00);
    rd(8'h71, 8'h00);
    rd(8'h72, 8'h00);
    rd(8'h7F, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_conv();
    wb(1'b1, 8'h70, 8'h25);
    poll(n);
    rd(8'h72, 8'h02);
    rd(8'h70, 8'hA5);
    rd(8'h71, 8'h5A);
    rd(8'h70, 8'h25);
    poll(n);
    rd(8'h71, 8'h5A);
    poll(n);
    wb(1'b1, 8'h70, 8'h25);
    rd(8'h70, 8'h25);
    $display("t_conv done");
  endtask : t_conv
  task automatic t_speed();
    wb(1'b1, 8'h70, 8'h00);
    wb(1'b1, 8'h70, 8'h25);
    n = cyc;
    poll(p);
    n = cyc - n;
    wb(1'b1, 8'h70, 8'h00);
    wb(1'b1, 8'h70, 8'h65);
    m = cyc;
    poll(p);
    m = cyc - m;
    chk("speed", 10'(n > m), 10'h1);
    $display("t_speed done");
  endtask : t_speed
  task automatic t_range();
    wb(1'b1, 8'h70, 8'h6F);
    poll(n);
    rd(8'h72, 8'h03);
    rd(8'h71, 8'hFF);
    wb(1'b1, 8'h70, 8'h60);
    poll(n);
    rd(8'h72, 8'h00);
    rd(8'h71, 8'h00);
    $display("t_range done");
  endtask : t_range
  task automatic t_abort();
    wb(1'b1, 8'h70, 8'h65);
    repeat (10) @(posedge CORE_CLK);
    wb(1'b1, 8'h70, 8'h66);
    rd(8'h70, 8'h66);
    poll(n);
    rd(8'h71, 8'h6A);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_off();
    wb(1'b1, 8'h70, 8'h05);
    repeat (80) @(posedge CORE_CLK);
    chk("power", {9'h0, CONVERTER_POWER}, 10'h0);
    rd(8'h70, 8'h05);
    wb(1'b1, 8'h70, 8'h25);
    HALT_MODE <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    chk("halt", {9'h0, CONVERTER_POWER}, 10'h0);
    HALT_MODE <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    chk("wake", {9'h0, CONVERTER_POWER}, 10'h1);
    $display("t_off done");
  endtask : t_off
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    t_reset();
    t_conv();
    t_speed();
    t_range();
    t_abort();
    t_off();
    finish_test();
  end
endmodule : tb
bind sar_adc_control sar_adc_control_assertions chk_i (.*);
